// [pkg/csp_pkg.sv]
package csp_pkg;

  // ********************************************************************
  // Register addresses
  // ********************************************************************
  localparam logic [15:0] CSP_MODE_ADDR   = 16'hffb0;
  localparam logic [15:0] CSP_HI_ADDR     = 16'hffb1;
  localparam logic [15:0] CSP_LO_ADDR     = 16'hffb2;
  localparam logic [15:0] CSP_LEVEL_ADDR  = 16'hffb3;
  localparam logic [15:0] CSP_PORTFN_ADDR = 16'hffec;
  localparam logic [15:0] CSP_DRV_ADDR    = 16'hffed;

  // ********************************************************************
  // Reset values and fixed bits
  // ********************************************************************
  localparam logic [7:0] CSP_MODE_RST     = 8'h80;
  localparam logic [7:0] CSP_PORTFN_RST   = 8'h00;
  localparam logic [7:0] CSP_DRV_RST      = 8'h97;
  localparam logic [7:0] CSP_DRV_RW_MASK  = 8'h68;
  localparam logic [6:0] CSP_LEVEL_RSVD   = 7'h7f;
  localparam logic       CSP_MODE_RSVD    = 1'b1;
  localparam logic [7:0] CSP_UNMAPPED_RD  = 8'h00;
  localparam logic       CSP_SI_IDLE      = 1'b1;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int CSP_OUT_SEL_BIT    = 3;
  localparam int CSP_IN_SEL_BIT     = 2;
  localparam int CSP_CLK_SEL_BIT    = 1;
  localparam int CSP_OPEN_DRAIN_BIT = 3;
  localparam int CSP_WIDTH_BIT      = 6;
  localparam int CSP_LEVEL_BIT      = 7;

  // ********************************************************************
  // Clock source codes, frame lengths, divider ratios
  // ********************************************************************
  localparam logic [3:0] CSP_EXT_CLK_CODE = 4'hf;
  localparam logic [4:0] CSP_FRAME8       = 5'h08;
  localparam logic [4:0] CSP_FRAME16      = 5'h10;
  localparam int CSP_DIV0 = 1024;
  localparam int CSP_DIV1 = 256;
  localparam int CSP_DIV2 = 64;
  localparam int CSP_DIV3 = 32;
  localparam int CSP_DIV4 = 16;
  localparam int CSP_DIV5 = 8;
  localparam int CSP_DIV6 = 4;
  localparam int CSP_DIV7 = 2;

  typedef enum logic [1:0] {
    CSP_START_PENDING,
    CSP_CLOCK_PENDING,
    CSP_TRANSFER
  } csp_state_e;

endpackage

// [rtl/csp_serial_unit_one.sv]
`timescale 1ns/1ps
module csp_serial_unit_one
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  // Transfer flag
  input  wire logic        irq_clear,
  output logic             transfer_irq_flag,
  // Serial clock pin
  input  wire logic        serial_clock_in,
  output logic             serial_clock_out,
  output logic             serial_clock_oe,
  // Serial data pins
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_oe
);
  import csp_pkg::*;

  // ********************************************************************
  // Register storage and decode
  // ********************************************************************
  logic [7:0]  serial_mode_register;
  logic [7:0]  high_data_shift_register;
  logic [7:0]  low_data_shift_register;
  logic        level_hold_bit;
  logic [7:0]  port_function_select_register;
  logic [7:0]  output_driver_config_register;
  csp_state_e  state;
  logic [4:0]  count;
  logic        armed;
  logic [9:0]  div_cnt;
  logic        sck_int;
  logic        ext_q;

  logic        wr_mode;
  logic        rd_mode;
  logic        output_pin_select;
  logic        input_pin_select;
  logic        clock_pin_select;
  logic        open_drain_select;
  logic        width_select_bit;
  logic [3:0]  clock_select;
  logic        int_src;
  logic        ext_src;
  logic        xfer_mode;
  logic        cont_mode;
  logic [4:0]  frame_len;
  logic        run;
  logic        tick;
  logic        fall_ev;
  logic        rise_ev;
  logic        start_ev;
  logic        shift_fall;
  logic        shift_rise;
  logic        done;
  logic        irq_set;
  logic        rx_bit;

  assign wr_mode = wr && (addr == CSP_MODE_ADDR);
  assign rd_mode = rd && (addr == CSP_MODE_ADDR);

  assign output_pin_select = port_function_select_register[CSP_OUT_SEL_BIT];
  assign input_pin_select  = port_function_select_register[CSP_IN_SEL_BIT];
  assign clock_pin_select  = port_function_select_register[CSP_CLK_SEL_BIT];
  assign open_drain_select =
    output_driver_config_register[CSP_OPEN_DRAIN_BIT];
  assign width_select_bit  = serial_mode_register[CSP_WIDTH_BIT];
  assign clock_select      = serial_mode_register[3:0];

  // Internal codes have the top clock bit clear; 8..14 give no clock
  assign int_src = clock_pin_select && !clock_select[3];
  assign ext_src = clock_pin_select
                   && (clock_select == CSP_EXT_CLK_CODE);

  // Mode table from mode bits and pin selects
  assign xfer_mode = (serial_mode_register[5:4] != 2'b00)
                     && clock_pin_select
                     && (output_pin_select || input_pin_select);
  assign cont_mode = (serial_mode_register[5:4] == 2'b00)
                     && clock_pin_select
                     && !output_pin_select
                     && !input_pin_select;
  assign frame_len = width_select_bit ? CSP_FRAME16 : CSP_FRAME8;

  // ********************************************************************
  // Prescaler and clock edges
  // ********************************************************************
  function automatic logic [9:0] half_m1(input logic [2:0] code);
    int ratio;
    ratio = CSP_DIV0;
    unique case (code)
      3'h0: ratio = CSP_DIV0;
      3'h1: ratio = CSP_DIV1;
      3'h2: ratio = CSP_DIV2;
      3'h3: ratio = CSP_DIV3;
      3'h4: ratio = CSP_DIV4;
      3'h5: ratio = CSP_DIV5;
      3'h6: ratio = CSP_DIV6;
      3'h7: ratio = CSP_DIV7;
    endcase
    return 10'(ratio / 2 - 1);
  endfunction

  // Internal clock runs only while a frame is armed or running, or while pending in clock-only mode
  assign run = int_src
               && ((state == CSP_TRANSFER)
                   || ((state == CSP_CLOCK_PENDING)
                       && ((armed && xfer_mode) || cont_mode)));
  assign tick = run && (div_cnt == half_m1(clock_select[2:0]));

  always_ff @(posedge clk)
  begin
    if (!resetn || !run)
    begin
      div_cnt <= 10'h000;
      sck_int <= 1'b1;
    end
    else if (tick)
    begin
      div_cnt <= 10'h000;
      sck_int <= !sck_int;
    end
    else
    begin
      div_cnt <= div_cnt + 10'h001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ext_q <= 1'b1;
    end
    else
    begin
      ext_q <= serial_clock_in;
    end
  end

  always_comb
  begin
    fall_ev = 1'b0;
    rise_ev = 1'b0;
    if (int_src)
    begin
      fall_ev = tick && sck_int;
      rise_ev = tick && !sck_int;
    end
    else if (ext_src)
    begin
      fall_ev = ext_q && !serial_clock_in;
      rise_ev = !ext_q && serial_clock_in;
    end
  end

  assign start_ev   = (state == CSP_CLOCK_PENDING) && fall_ev && xfer_mode;
  assign shift_fall = start_ev || ((state == CSP_TRANSFER) && fall_ev);
  assign shift_rise = (state == CSP_TRANSFER) && rise_ev;
  assign done       = shift_rise && (count == frame_len - 5'h01);

  // ********************************************************************
  // Transfer state and counter
  // ********************************************************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state <= CSP_START_PENDING;
      count <= 5'h00;
      armed <= 1'b0;
    end
    else if (wr_mode)
    begin
      state <= CSP_START_PENDING;
      count <= 5'h00;
      armed <= 1'b0;
    end
    else if (rd_mode)
    begin
      state <= CSP_CLOCK_PENDING;
      count <= 5'h00;
      armed <= 1'b1;
    end
    else
    begin
      unique case (state)
        CSP_START_PENDING:
        begin
          count <= 5'h00;
        end
        CSP_CLOCK_PENDING:
        begin
          if (start_ev)
          begin
            state <= CSP_TRANSFER;
          end
        end
        CSP_TRANSFER:
        begin
          if (done)
          begin
            state <= CSP_CLOCK_PENDING;
            count <= 5'h00;
            armed <= 1'b0;
          end
          else if (shift_rise)
          begin
            count <= count + 5'h01;
          end
        end
      endcase
    end
  end

  // ********************************************************************
  // Transfer flag
  // ********************************************************************
  assign irq_set = done
                   || ((wr_mode || rd_mode)
                       && (state == CSP_TRANSFER));

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      transfer_irq_flag <= 1'b0;
    end
    else if (irq_set)
    begin
      transfer_irq_flag <= 1'b1;
    end
    else if (irq_clear)
    begin
      transfer_irq_flag <= 1'b0;
    end
  end

  // ********************************************************************
  // Data shift path
  // ********************************************************************
  assign rx_bit = input_pin_select ? serial_data_in : CSP_SI_IDLE;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      high_data_shift_register <= 8'h00;
      low_data_shift_register  <= 8'h00;
      level_hold_bit           <= 1'b0;
    end
    else if (wr && (addr == CSP_HI_ADDR))
    begin
      high_data_shift_register <= wdata;
    end
    else if (wr && (addr == CSP_LO_ADDR))
    begin
      low_data_shift_register <= wdata;
    end
    else if (wr && (addr == CSP_LEVEL_ADDR))
    begin
      level_hold_bit <= wdata[CSP_LEVEL_BIT];
    end
    else if (shift_fall)
    begin
      level_hold_bit <= low_data_shift_register[0];
      low_data_shift_register <=
        {high_data_shift_register[0], low_data_shift_register[7:1]};
      high_data_shift_register <= {1'b0, high_data_shift_register[7:1]};
    end
    else if (shift_rise)
    begin
      if (width_select_bit)
      begin
        high_data_shift_register[7] <= rx_bit;
      end
      else
      begin
        low_data_shift_register[7] <= rx_bit;
      end
    end
  end

  // ********************************************************************
  // Configuration registers
  // ********************************************************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      serial_mode_register          <= CSP_MODE_RST;
      port_function_select_register <= CSP_PORTFN_RST;
      output_driver_config_register <= CSP_DRV_RST;
    end
    else if (wr)
    begin
      if (addr == CSP_MODE_ADDR)
      begin
        serial_mode_register <= {CSP_MODE_RSVD, wdata[6:0]};
      end
      if (addr == CSP_PORTFN_ADDR)
      begin
        port_function_select_register <= wdata;
      end
      if (addr == CSP_DRV_ADDR)
      begin
        output_driver_config_register <= (wdata & CSP_DRV_RW_MASK)
                                         | (CSP_DRV_RST & ~CSP_DRV_RW_MASK);
      end
    end
  end

  // ********************************************************************
  // Read data
  // ********************************************************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rdata <= 8'h00;
    end
    else if (rd)
    begin
      unique case (addr)
        CSP_MODE_ADDR:   rdata <= serial_mode_register;
        CSP_HI_ADDR:     rdata <= high_data_shift_register;
        CSP_LO_ADDR:     rdata <= low_data_shift_register;
        CSP_LEVEL_ADDR:  rdata <= {level_hold_bit, CSP_LEVEL_RSVD};
        CSP_PORTFN_ADDR: rdata <= port_function_select_register;
        CSP_DRV_ADDR:    rdata <= output_driver_config_register;
        default:         rdata <= CSP_UNMAPPED_RD;
      endcase
    end
  end

  // ********************************************************************
  // Pins
  // ********************************************************************
  assign serial_clock_out = sck_int;
  assign serial_clock_oe  = int_src;
  assign serial_data_out  = level_hold_bit;
  assign serial_data_oe   = output_pin_select
                            && !(open_drain_select
                                 && level_hold_bit);

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_last_rise;
    (state == CSP_TRANSFER) && rise_ev && (count == frame_len - 5'h01);
  endsequence

  sequence s_back_pending;
    (state == CSP_CLOCK_PENDING) && (count == 5'h00) && transfer_irq_flag;
  endsequence

  a_frame_done_flag: assert property (s_last_rise |=> s_back_pending)
    else $error("frame end did not clear counter and set flag");

  a_level_read_ones: assert property (
    rd && (addr == CSP_LEVEL_ADDR) |=> rdata[6:0] == 7'h7f)
    else $error("level register low bits not read as ones");

  a_level_write_pin: assert property (
    wr && (addr == CSP_LEVEL_ADDR) |=> serial_data_out == $past(wdata[7]))
    else $error("data output did not follow level hold write");

  a_disabled_no_xfer: assert property (
    (port_function_select_register[3:1] == 3'b000)
    && (state != CSP_TRANSFER) && !wr |=> state != CSP_TRANSFER)
    else $error("transfer started with all pins deselected");

  a_mode_write_abort: assert property (
    wr_mode && (state == CSP_TRANSFER)
    |=> (state == CSP_START_PENDING) && transfer_irq_flag && (count == 0))
    else $error("mode write did not abort transfer");

  a_dummy_read_error: assert property (
    rd_mode && !wr && (state == CSP_TRANSFER)
    |=> transfer_irq_flag && (count == 0) && (state == CSP_CLOCK_PENDING))
    else $error("dummy read during transfer not flagged");

  a_ext_clk_input: assert property (
    clock_pin_select && (clock_select == 4'hf) |-> !serial_clock_oe)
    else $error("clock pin driven with external source");

  a_clock_stops: assert property (
    int_src && (state == CSP_CLOCK_PENDING) && !armed && !cont_mode && !wr
    |=> $stable(serial_clock_out)[*2])
    else $error("internal clock ran outside a transfer");

  a_open_drain_off: assert property (
    open_drain_select && serial_data_out |-> !serial_data_oe)
    else $error("open-drain output drove a high level");

  a_flag_set_wins: assert property (
    irq_set && irq_clear |=> transfer_irq_flag)
    else $error("flag clear beat a set in the same cycle");

  a_rise_counts: assert property (
    shift_rise && !done && !wr_mode && !rd_mode
    |=> count == $past(count) + 5'h01)
    else $error("counter did not step on rising edge");

endmodule

// [sim/csp_far_device.sv]
`timescale 1ns/1ps
module csp_far_device
(
  // Pin levels seen by the far device
  input  wire logic sck,
  input  wire logic sdo,
  // Pins driven by the far device
  output logic      sdi,
  output logic      ext_sck
);
  logic [15:0] rx_word;
  logic [15:0] tx_word;
  int          n_fall;

  initial
  begin
    sdi = 1'b1;
    ext_sck = 1'b1;
    rx_word = 16'h0000;
    tx_word = 16'hffff;
    n_fall = 0;
  end

  // ******************************************************************
  // Serial shifting
  // ******************************************************************
  always @(posedge sck)
  begin
    rx_word <= {sdo, rx_word[15:1]};
  end

  always @(negedge sck)
  begin
    sdi <= tx_word[0];
    tx_word <= {~tx_word[0], tx_word[15:1]};
    n_fall <= n_fall + 1;
  end

  // ******************************************************************
  // Control from the bench
  // ******************************************************************
  task automatic load(input logic [15:0] tx);
    tx_word = tx;
    rx_word = 16'h0000;
    n_fall = 0;
  endtask

  // Clock stands high outside frames, phase kept off the system clock
  task automatic ext_clock(input int n, input int half);
    #7;
    repeat (n)
    begin
      ext_sck = 1'b0;
      #(half * 25);
      ext_sck = 1'b1;
      #(half * 25);
    end
  endtask
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import csp_pkg::*;
  logic        clk;
  logic        resetn;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        irq_clear;
  logic        flag;
  logic        sck_out;
  logic        sck_oe;
  logic        sdo;
  logic        sdo_oe;
  logic        sdi;
  logic        ext_sck;
  logic [7:0]  d;
  int          n_fail;
  int          n_tests;
  int          c;
  int          n;
  int          divs [8];
  wire         sck_pin = sck_oe ? sck_out : ext_sck;
  wire         sdo_pin = sdo_oe ? sdo : 1'b1;

  csp_serial_unit_one DUT (.clk(clk), .resetn(resetn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq_clear(irq_clear),
    .transfer_irq_flag(flag), .serial_clock_in(sck_pin),
    .serial_clock_out(sck_out), .serial_clock_oe(sck_oe),
    .serial_data_in(sdi), .serial_data_out(sdo), .serial_data_oe(sdo_oe));

  csp_far_device far (.sck(sck_pin), .sdo(sdo_pin), .sdi(sdi),
    .ext_sck(ext_sck));

  initial
  begin
    clk = 1'b0;
    forever
      #12.5 clk = ~clk;
  end

  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic chk_rd(input logic [15:0] a, input logic [7:0] exp);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
    @(posedge clk);
  endtask

  task automatic dummy_rd;
    rd <= 1'b1;
    addr <= CSP_MODE_ADDR;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic clr_flag;
    irq_clear <= 1'b1;
    @(posedge clk);
    irq_clear <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_flag(input int bound);
    for (int i = 0; i <= bound; i++)
    begin
      @(posedge clk);
      #1;
      if (flag === 1'b1)
        return;
    end
    n_fail++;
    $display("ERROR %0t: flag wait ran out", $time);
    wrap_up();
  endtask

  task automatic count_falls(input int cycles, output int nf);
    logic prev;
    nf = 0;
    prev = sck_pin;
    repeat (cycles)
    begin
      @(posedge clk);
      #1;
      if (prev === 1'b1 && sck_pin === 1'b0)
        nf++;
      prev = sck_pin;
    end
  endtask

  task automatic next_fall(output int cyc);
    logic prev;
    prev = sck_pin;
    for (cyc = 1; cyc < 3000; cyc++)
    begin
      @(posedge clk);
      #1;
      if (prev === 1'b1 && sck_pin === 1'b0)
        return;
      prev = sck_pin;
    end
    n_fail++;
    $display("ERROR %0t: clock edge wait ran out", $time);
    wrap_up();
  endtask

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial
  begin
    divs = '{CSP_DIV0, CSP_DIV1, CSP_DIV2, CSP_DIV3,
             CSP_DIV4, CSP_DIV5, CSP_DIV6, CSP_DIV7};
    n_fail = 0;
    n_tests = 0;
    resetn = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    irq_clear = 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk_rd(CSP_LEVEL_ADDR, 8'h7f);
    chk_rd(CSP_PORTFN_ADDR, CSP_PORTFN_RST);
    chk_rd(CSP_DRV_ADDR, CSP_DRV_RST);
    chk_rd(16'hffc0, CSP_UNMAPPED_RD);
    chk_rd(CSP_MODE_ADDR, CSP_MODE_RST);
    check(sdo_oe, 1'b0);
    check(sck_oe, 1'b0);
    // Level hold bit drives the output pin directly
    wr_reg(CSP_PORTFN_ADDR, 8'h08);
    check(sdo_oe, 1'b1);
    wr_reg(CSP_LEVEL_ADDR, 8'h80);
    check(sdo, 1'b1);
    chk_rd(CSP_LEVEL_ADDR, 8'hff);
    wr_reg(CSP_LEVEL_ADDR, 8'h00);
    check(sdo, 1'b0);
    chk_rd(CSP_LEVEL_ADDR, 8'h7f);
    // Open-drain releases the pin for a high level
    wr_reg(CSP_DRV_ADDR, 8'hff);
    chk_rd(CSP_DRV_ADDR, 8'hff);
    check(sdo_oe, 1'b1);
    wr_reg(CSP_LEVEL_ADDR, 8'h80);
    check(sdo_oe, 1'b0);
    wr_reg(CSP_DRV_ADDR, 8'h00);
    chk_rd(CSP_DRV_ADDR, CSP_DRV_RST);
    check(sdo_oe, 1'b1);
    // No pins selected: nothing moves
    wr_reg(CSP_PORTFN_ADDR, 8'h00);
    wr_reg(CSP_MODE_ADDR, 8'h17);
    dummy_rd();
    count_falls(20, n);
    check(n, 0);
    // External edges with no pin selected start nothing either
    wr_reg(CSP_MODE_ADDR, 8'h1f);
    dummy_rd();
    far.ext_clock(8, 1);
    @(posedge clk);
    check(flag, 1'b0);
    // Unused clock codes give no clock at all
    wr_reg(CSP_PORTFN_ADDR, 8'h0a);
    wr_reg(CSP_MODE_ADDR, 8'h18);
    dummy_rd();
    count_falls(20, n);
    check(n, 0);
    check(sck_oe, 1'b0);
    check(flag, 1'b0);
    // Only the clock pin selected with mode bits 00
    wr_reg(CSP_PORTFN_ADDR, 8'h02);
    wr_reg(CSP_MODE_ADDR, 8'h07);
    dummy_rd();
    count_falls(20, n);
    check(n, 10);
    check(flag, 1'b0);
    // 8-bit transmit at every internal ratio
    wr_reg(CSP_PORTFN_ADDR, 8'h0a);
    for (int k = 0; k < 8; k++)
    begin
      d = 8'h5a ^ 8'(k * 8'h13);
      wr_reg(CSP_MODE_ADDR, 8'h10 | 8'(k));
      wr_reg(CSP_LO_ADDR, d);
      far.load(16'hffff);
      dummy_rd();
      next_fall(c);
      next_fall(c);
      check(c, divs[k]);
      check(sck_oe, 1'b1);
      wait_flag(9000);
      check(far.rx_word[15:8], d);
      check(sdo, d[7]);
      count_falls(40, n);
      check(n, 0);
      check(sdo, d[7]);
      clr_flag();
    end
    // 16-bit full duplex
    wr_reg(CSP_PORTFN_ADDR, 8'h0e);
    wr_reg(CSP_MODE_ADDR, 8'h56);
    wr_reg(CSP_HI_ADDR, 8'h12);
    wr_reg(CSP_LO_ADDR, 8'h34);
    far.load(16'hbeef);
    dummy_rd();
    wait_flag(200);
    check(far.rx_word, 16'h1234);
    check(far.n_fall, 16);
    chk_rd(CSP_HI_ADDR, 8'hbe);
    chk_rd(CSP_LO_ADDR, 8'hef);
    clr_flag();
    // Dummy read inside a frame is an error
    wr_reg(CSP_PORTFN_ADDR, 8'h0a);
    wr_reg(CSP_MODE_ADDR, 8'h10);
    dummy_rd();
    repeat (1200) @(posedge clk);
    check(flag, 1'b0);
    dummy_rd();
    wait_flag(4);
    check(flag, 1'b1);
    clr_flag();
    // Mode write inside a frame aborts it
    repeat (1200) @(posedge clk);
    wr_reg(CSP_MODE_ADDR, 8'h10);
    wait_flag(4);
    check(flag, 1'b1);
    count_falls(2100, n);
    check(n, 0);
    clr_flag();
    // External clock keeps running past one frame
    wr_reg(CSP_MODE_ADDR, 8'h1f);
    wr_reg(CSP_LO_ADDR, 8'h3c);
    far.load(16'h0000);
    dummy_rd();
    check(sck_oe, 1'b0);
    far.ext_clock(16, 4);
    repeat (4) @(posedge clk);
    check(far.rx_word, 16'hff3c);
    check(flag, 1'b1);
    wrap_up();
  end
endmodule
